// ---- rtl/dcb_params.svh ----
`ifndef DCB_PARAMS_SVH
`define DCB_PARAMS_SVH
// Register indices; byte address is four times the index
`define DCB_IDX_POS     7'h3c
`define DCB_IDX_SEG0    7'h3d
`define DCB_IDX_SEG1    7'h3e
`define DCB_IDX_SEG2    7'h3f
`define DCB_IDX_CLK     7'h40
`define DCB_IDX_PORT    7'h41
`define DCB_IDX_NLK     7'h42
`define DCB_IDX_FE      7'h43
// Non-volatile image
`define DCB_EEP_FIRST   6'd36
`define DCB_EEP_LAST    6'd47
`define DCB_EEP_WORDS   2'd3
// Clock and display control fields
`define DCB_CLK_DITHER  23
`define DCB_CLK_EXTSPI  22
`define DCB_CLK_RCH     21:20
`define DCB_CLK_DIRECT  19
`define DCB_CLK_SRC     18
`define DCB_CLK_DISCH   17
`define DCB_CLK_MPSEL   3:0
// Port control fields
`define DCB_PRT_DELAY   23:21
`define DCB_PRT_PULSE   20:17
`define DCB_PRT_DIV     16:11
`define DCB_PRT_SPIOUT  10:8
`define DCB_PRT_AUXV    7:6
`define DCB_PRT_DIR5    5:4
`define DCB_PRT_DIR4    3:2
`define DCB_PRT_KSYNC   1:0
// Front-end fields
`define DCB_FE_RES      1:0
`define DCB_FE_COMP     3:2
// Timing
`define DCB_CLK_NS      10
`define DCB_MS_NS       1000000
`define DCB_MS_CYC      (`DCB_MS_NS / `DCB_CLK_NS)
`define DCB_PUMP_BASE   10'd480
`define DCB_MPSEL_IRQ   4'hc
`endif

// ---- rtl/dcb_pkg.sv ----
`include "dcb_params.svh"
package dcb_pkg;
    typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} dcb_ld_t;

    typedef struct packed {
        dcb_ld_t     ld_st;
        logic [1:0]  ld_word;
        logic [1:0]  ld_byte;
        logic [23:0] ld_acc;
        logic        eep_rd;
        logic [5:0]  eep_addr;
        logic [23:0] pos;
        logic [23:0] seg0;
        logic [23:0] seg1;
        logic [23:0] seg2;
        logic [23:0] clk;
        logic [23:0] port;
        logic [23:0] nlk;
        logic [23:0] fe;
        logic        ack;
        logic [23:0] dat;
        logic [2:0]  s_osc;
        logic [1:0]  s_aux1;
        logic [1:0]  s_aux2;
        logic [9:0]  pdiv;
        logic        pump_tick;
        logic [7:0]  lfsr;
        logic [1:0]  rc_cnt;
        logic        recharge;
        logic [8:0]  sck_cnt;
        logic        sck;
        logic [16:0] ms_pre;
        logic [10:0] ms_cnt;
        logic        disp_on;
        logic        comp_on;
        logic [9:0]  res_kohm;
        logic        mp3;
        logic [1:0]  aux_o;
        logic [1:0]  aux_oe;
        logic [1:0]  aux_pu;
        logic [1:0]  aux_pd;
        logic        loaded;
    } dcb_state_t;
endpackage : dcb_pkg

// ---- rtl/dcb_top.sv ----
// Behaviour
// - Fast-charge resistor code selects 30/50/200/800 kohm
// - Comparator mode: off, off-between, off-load-between, on
// - Segment position word at 60, image bytes 36-38
// - Segment data 56 bits over three words
// - Segment data words 61-63 never loaded from image
// - Dither adds noise to derived pump divider
// - External display enable turns pins into serial
// - Recharge every (n+1)th display cycle
// - Direct-drive bit drives display from supply
// - Pump clock source: divided 4 MHz or 10 kHz
// - Fast-discharge bit enables capacitor fast discharge
// - Diagnostic select routes third multipurpose pin
// - Delay field sets serial clock period 500ns-10us
// - Upper pulsed bits set blink period
// - Lower pulsed bits set on-time
// - Derived pump divider equals 480 plus offset
// - Serial-out field switches pin groups, bit0 first
// - Aux value drives outputs, reads inputs' levels
// - Aux direction: out, pull-up, pull-down, input
// - Key synchronisation speed field
// - Clock word at 64, port word at 65
// - Nonlinearity multiplier word at 66
// - Power-on copy of image into configuration words
// - Three successive bytes form one 24-bit word
//
// Local design decision: the Wishbone interface to the registers.
`include "dcb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dcb_top
    import dcb_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `DCB_MS_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [8:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Non-volatile image port
    output logic             eep_rd_o,
    output logic [5:0]       eep_addr_o,
    input  wire logic        eep_valid_i,
    input  wire logic [7:0]  eep_data_i,
    // Timing sources
    input  wire logic        tick_4mhz_i,
    input  wire logic        osc_10k_i,
    input  wire logic        disp_cycle_i,
    input  wire logic        meas_active_i,
    input  wire logic        loading_i,
    // Multipurpose pin sources
    input  wire logic        mp3_gpio_i,
    input  wire logic [11:1] diag_i,
    input  wire logic        irq_i,
    // Auxiliary pins four and five
    input  wire logic [1:0]  aux_pin_i,
    output logic [1:0]       aux_pin_o,
    output logic [1:0]       aux_pin_oe_o,
    output logic [1:0]       aux_pull_up_o,
    output logic [1:0]       aux_pull_down_o,
    // Display controls
    output logic [23:0]      seg_position_o,
    output logic [55:0]      seg_data_o,
    output logic [9:0]       charge_res_kohm_o,
    output logic             comp_on_o,
    output logic             fast_discharge_o,
    output logic             ext_display_o,
    output logic             ext_sck_o,
    output logic [2:0]       seg_spi_out_o,
    output logic             first_common_pin_spi_o,
    output logic             direct_drive_o,
    output logic             recharge_o,
    output logic             pump_tick_o,
    output logic             display_on_o,
    output logic             third_multipurpose_pin_o,
    output logic [1:0]       key_sync_speed_o,
    output logic [23:0]      nonlinearity_multiplier_o,
    output logic             config_loaded_o
);

    dcb_state_t r;
    dcb_state_t n;

    function automatic logic [9:0] kohm(input logic [1:0] c);
        case (c)
            2'h0:    kohm = 10'd30;
            2'h1:    kohm = 10'd50;
            2'h2:    kohm = 10'd200;
            default: kohm = 10'd800;
        endcase
    endfunction : kohm

    // Half periods at 100 MHz; 0 gives 500 ns, 7 gives 10 us
    function automatic logic [8:0] sck_half(input logic [2:0] c);
        case (c)
            3'h0:    sck_half = 9'd25;
            3'h1:    sck_half = 9'd40;
            3'h2:    sck_half = 9'd70;
            3'h3:    sck_half = 9'd100;
            3'h4:    sck_half = 9'd150;
            3'h5:    sck_half = 9'd250;
            3'h6:    sck_half = 9'd350;
            default: sck_half = 9'd500;
        endcase
    endfunction : sck_half

    function automatic logic [10:0] blink_ms(input logic [1:0] c);
        case (c)
            2'h0:    blink_ms = 11'd300;
            2'h1:    blink_ms = 11'd600;
            2'h2:    blink_ms = 11'd1000;
            default: blink_ms = 11'd2000;
        endcase
    endfunction : blink_ms

    function automatic logic [10:0] on_ms(input logic [1:0] c);
        case (c)
            2'h0:    on_ms = 11'd0;
            2'h1:    on_ms = 11'd100;
            2'h2:    on_ms = 11'd200;
            default: on_ms = 11'd400;
        endcase
    endfunction : on_ms

    function automatic logic [23:0] merge(input logic [23:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
        merge = old;
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction : merge

    function automatic logic [6:0] image_index(input logic [1:0] w);
        case (w)
            2'h0:    image_index = `DCB_IDX_POS;
            2'h1:    image_index = `DCB_IDX_CLK;
            2'h2:    image_index = `DCB_IDX_PORT;
            default: image_index = `DCB_IDX_NLK;
        endcase
    endfunction : image_index

    logic        req;
    logic [6:0]  idx;
    logic [9:0]  pump_top;
    logic [1:0]  dir [2];
    logic [1:0]  aux_rd;

    assign req = wb_cyc_i && wb_stb_i && !r.ack && (r.ld_st == LD_DONE);
    assign idx = wb_adr_i[8:2];
    assign dir[0] = r.port[`DCB_PRT_DIR4];
    assign dir[1] = r.port[`DCB_PRT_DIR5];

    // Derived divider with optional noise on the low bits
    assign pump_top = `DCB_PUMP_BASE + {4'h0, r.port[`DCB_PRT_DIV]}
                    + {8'h00, r.clk[`DCB_CLK_DITHER] ? r.lfsr[1:0] : 2'h0};

    for (genvar g = 0; g < 2; g++) begin : g_aux
        // Output reads back the driven value, input reads the pin
        assign aux_rd[g] = (dir[g] == 2'h0) ? r.port[6 + g] : r.s_aux2[g];
    end

    always_comb begin
        logic [23:0] rd;
        logic        wr;
        rd = 24'h000000;
        wr = req && wb_we_i;
        n = r;
        n.eep_rd = 1'b0;
        n.pump_tick = 1'b0;
        n.recharge = 1'b0;
        n.ack = 1'b0;

        // Power-on copy, three bytes per word, first byte highest
        case (r.ld_st)
            LD_REQ: begin
                n.eep_rd = 1'b1;
                n.eep_addr = `DCB_EEP_FIRST + 6'(r.ld_word) * 6'd3
                           + {4'h0, r.ld_byte};
                n.ld_st = LD_WAIT;
            end
            LD_WAIT: begin
                if (eep_valid_i) begin
                    n.ld_acc = {r.ld_acc[15:0], eep_data_i};
                    n.ld_st = LD_REQ;
                    n.ld_byte = r.ld_byte + 2'h1;
                    if (r.ld_byte == 2'h2) begin
                        n.ld_byte = 2'h0;
                        n.ld_word = r.ld_word + 2'h1;
                        // Segment data words are skipped by the map
                        case (image_index(r.ld_word))
                            `DCB_IDX_POS:  n.pos  = {r.ld_acc[15:0], eep_data_i};
                            `DCB_IDX_CLK:  n.clk  = {r.ld_acc[15:0], eep_data_i};
                            `DCB_IDX_PORT: n.port = {r.ld_acc[15:0], eep_data_i};
                            default:       n.nlk  = {r.ld_acc[15:0], eep_data_i};
                        endcase
                        if (r.ld_word == `DCB_EEP_WORDS) begin
                            n.ld_st = LD_DONE;
                        end
                    end
                end
            end
            LD_DONE: begin
                n.ld_st = LD_DONE;
            end
            default: begin
                n.ld_st = LD_REQ;
            end
        endcase
        n.loaded = n.ld_st == LD_DONE;

        // Bus slave: one wait state, unmapped reads zero
        case (idx)
            `DCB_IDX_POS:  rd = r.pos;
            `DCB_IDX_SEG0: rd = r.seg0;
            `DCB_IDX_SEG1: rd = r.seg1;
            `DCB_IDX_SEG2: rd = {16'h0000, r.seg2[7:0]};
            `DCB_IDX_CLK:  rd = r.clk;
            `DCB_IDX_PORT: rd = {r.port[23:8], aux_rd, r.port[5:0]};
            `DCB_IDX_NLK:  rd = r.nlk;
            `DCB_IDX_FE:   rd = {20'h00000, r.fe[3:0]};
            default:       rd = 24'h000000;
        endcase
        if (req) begin
            n.ack = 1'b1;
            n.dat = rd;
        end
        if (wr) begin
            case (idx)
                `DCB_IDX_POS:  n.pos  = merge(r.pos, wb_dat_i, wb_sel_i);
                `DCB_IDX_SEG0: n.seg0 = merge(r.seg0, wb_dat_i, wb_sel_i);
                `DCB_IDX_SEG1: n.seg1 = merge(r.seg1, wb_dat_i, wb_sel_i);
                `DCB_IDX_SEG2: n.seg2 = merge(r.seg2, wb_dat_i, wb_sel_i) & 24'h0000ff;
                `DCB_IDX_CLK:  n.clk  = merge(r.clk, wb_dat_i, wb_sel_i);
                `DCB_IDX_PORT: n.port = merge(r.port, wb_dat_i, wb_sel_i);
                `DCB_IDX_NLK:  n.nlk  = merge(r.nlk, wb_dat_i, wb_sel_i);
                `DCB_IDX_FE:   n.fe   = merge(r.fe, wb_dat_i, wb_sel_i) & 24'h00000f;
                default:       n.fe   = r.fe;
            endcase
        end

        // Pin synchronisers
        n.s_osc = {r.s_osc[1:0], osc_10k_i};
        n.s_aux1 = aux_pin_i;
        n.s_aux2 = r.s_aux1;

        // Charge-pump clock
        if (r.clk[`DCB_CLK_SRC]) begin
            n.pump_tick = r.s_osc[1] && !r.s_osc[2];
            n.pdiv = 10'h000;
        end else if (tick_4mhz_i) begin
            if (r.pdiv >= pump_top - 10'h001) begin
                n.pdiv = 10'h000;
                n.pump_tick = 1'b1;
                n.lfsr = {r.lfsr[6:0], r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3]};
            end else begin
                n.pdiv = r.pdiv + 10'h001;
            end
        end

        // Recharge divider
        if (disp_cycle_i) begin
            if (r.rc_cnt >= r.clk[`DCB_CLK_RCH]) begin
                n.rc_cnt = 2'h0;
                n.recharge = 1'b1;
            end else begin
                n.rc_cnt = r.rc_cnt + 2'h1;
            end
        end

        // External display serial clock, idle low when unused
        if (!r.clk[`DCB_CLK_EXTSPI]) begin
            n.sck = 1'b0;
            n.sck_cnt = 9'h000;
        end else if (r.sck_cnt >= sck_half(r.port[`DCB_PRT_DELAY]) - 9'h001) begin
            n.sck = !r.sck;
            n.sck_cnt = 9'h000;
        end else begin
            n.sck_cnt = r.sck_cnt + 9'h001;
        end

        // Pulsed display; a zero on-time keeps it dark
        if (r.ms_pre >= 17'(MS_CYCLES - 1)) begin
            n.ms_pre = 17'h00000;
            if (r.ms_cnt >= blink_ms(r.port[20:19]) - 11'h001) begin
                n.ms_cnt = 11'h000;
            end else begin
                n.ms_cnt = r.ms_cnt + 11'h001;
            end
        end else begin
            n.ms_pre = r.ms_pre + 17'h00001;
        end
        n.disp_on = r.ms_cnt < on_ms(r.port[18:17]);

        // Comparator power
        case (r.fe[`DCB_FE_COMP])
            2'h0:    n.comp_on = 1'b0;
            2'h1:    n.comp_on = meas_active_i;
            2'h2:    n.comp_on = meas_active_i && !loading_i;
            default: n.comp_on = 1'b1;
        endcase
        n.res_kohm = kohm(r.fe[`DCB_FE_RES]);

        // Third multipurpose pin routing
        if (r.clk[`DCB_CLK_MPSEL] == 4'h0) begin
            n.mp3 = mp3_gpio_i;
        end else if (r.clk[`DCB_CLK_MPSEL] == `DCB_MPSEL_IRQ) begin
            n.mp3 = irq_i;
        end else if (r.clk[`DCB_CLK_MPSEL] < `DCB_MPSEL_IRQ) begin
            n.mp3 = diag_i[r.clk[`DCB_CLK_MPSEL]];
        end else begin
            n.mp3 = 1'b0;
        end

        // Auxiliary pins
        for (int i = 0; i < 2; i++) begin
            n.aux_oe[i] = dir[i] == 2'h0;
            n.aux_pu[i] = dir[i] == 2'h1;
            n.aux_pd[i] = dir[i] == 2'h2;
            n.aux_o[i] = r.port[6 + i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.ld_st <= LD_REQ;
            r.lfsr <= 8'h01;
            r.res_kohm <= 10'd30;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign wb_dat_o = {8'h00, r.dat};
    assign wb_ack_o = r.ack;
    assign eep_rd_o = r.eep_rd;
    assign eep_addr_o = r.eep_addr;
    assign aux_pin_o = r.aux_o;
    assign aux_pin_oe_o = r.aux_oe;
    assign aux_pull_up_o = r.aux_pu;
    assign aux_pull_down_o = r.aux_pd;
    assign seg_position_o = r.pos;
    assign seg_data_o = {r.seg2[7:0], r.seg1, r.seg0};
    assign charge_res_kohm_o = r.res_kohm;
    assign comp_on_o = r.comp_on;
    assign fast_discharge_o = r.clk[`DCB_CLK_DISCH];
    assign ext_display_o = r.clk[`DCB_CLK_EXTSPI];
    assign ext_sck_o = r.sck;
    assign seg_spi_out_o = r.port[`DCB_PRT_SPIOUT];
    assign first_common_pin_spi_o = r.port[8];
    assign direct_drive_o = r.clk[`DCB_CLK_DIRECT];
    assign recharge_o = r.recharge;
    assign pump_tick_o = r.pump_tick;
    assign display_on_o = r.disp_on;
    assign third_multipurpose_pin_o = r.mp3;
    assign key_sync_speed_o = r.port[`DCB_PRT_KSYNC];
    assign nonlinearity_multiplier_o = r.nlk;
    assign config_loaded_o = r.loaded;

    property p_res;
        @(posedge clk_i) disable iff (rst_i)
        ce_i |=> charge_res_kohm_o == kohm($past(r.fe[1:0]));
    endproperty
    a_res: assert property (p_res) else $error("resistor decode wrong");

    property p_comp_off;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && r.fe[3:2] == 2'h0) |=> !comp_on_o;
    endproperty
    a_comp_off: assert property (p_comp_off) else $error("comparator not off");

    property p_comp_meas;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && r.fe[3] != r.fe[2])
            |=> comp_on_o == ($past(meas_active_i) && ($past(r.fe[2]) || !$past(loading_i)));
    endproperty
    a_comp_meas: assert property (p_comp_meas) else $error("comparator mode wrong");

    property p_no_ack_loading;
        @(posedge clk_i) disable iff (rst_i)
        (r.ld_st != LD_DONE) |=> !wb_ack_o;
    endproperty
    a_no_ack_loading: assert property (p_no_ack_loading) else $error("ack during load");

    property p_image_range;
        @(posedge clk_i) disable iff (rst_i)
        eep_rd_o |-> (eep_addr_o >= `DCB_EEP_FIRST && eep_addr_o <= `DCB_EEP_LAST);
    endproperty
    a_image_range: assert property (p_image_range) else $error("image address out of range");

    property p_write;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && req && wb_we_i && idx == `DCB_IDX_CLK && wb_sel_i == 4'hf)
            |=> r.clk == $past(wb_dat_i[23:0]);
    endproperty
    a_write: assert property (p_write) else $error("write not applied");

    property p_recharge;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && disp_cycle_i && r.rc_cnt >= r.clk[21:20]) |=> recharge_o;
    endproperty
    a_recharge: assert property (p_recharge) else $error("recharge missed");

    property p_recharge_skip;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !(disp_cycle_i && r.rc_cnt >= r.clk[21:20])) |=> !recharge_o;
    endproperty
    a_recharge_skip: assert property (p_recharge_skip) else $error("recharge too early");

    property p_mp3_irq;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && r.clk[3:0] == `DCB_MPSEL_IRQ) |=> third_multipurpose_pin_o == $past(irq_i);
    endproperty
    a_mp3_irq: assert property (p_mp3_irq) else $error("interrupt not routed");

    property p_aux_out;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && r.port[3:2] == 2'h0) |=> aux_pin_oe_o[0] && aux_pin_o[0] == $past(r.port[6]);
    endproperty
    a_aux_out: assert property (p_aux_out) else $error("aux output wrong");

endmodule : dcb_top
`default_nettype wire

// ---- bench/dcb_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcb_top_tb
    import dcb_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_ack_o, eep_rd_o;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, eep_valid_i = 1'b0;
    logic        tick_4mhz_i = 1'b0, osc_10k_i = 1'b0, disp_cycle_i = 1'b0, meas_active_i = 1'b0;
    logic        loading_i = 1'b0, mp3_gpio_i = 1'b0, irq_i = 1'b0;
    logic [8:0]  wb_adr_i = 9'h000;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pw;
    logic [5:0]  eep_addr_o;
    logic [7:0]  eep_data_i = 8'h00;
    logic [11:1] diag_i = 11'h000;
    logic [1:0]  aux_pin_i = 2'h0, aux_pin_o, aux_pin_oe_o, aux_pull_up_o, aux_pull_down_o;
    logic [1:0]  key_sync_speed_o;
    logic [23:0] seg_position_o, nonlinearity_multiplier_o;
    logic [55:0] seg_data_o;
    logic [9:0]  charge_res_kohm_o;
    logic [2:0]  seg_spi_out_o;
    logic        comp_on_o, fast_discharge_o, ext_display_o, ext_sck_o, first_common_pin_spi_o;
    logic        direct_drive_o, recharge_o, pump_tick_o, display_on_o;
    logic        third_multipurpose_pin_o, config_loaded_o, rc_on = 1'b0;
    int          err_total = 0, comparisons = 0, ld_n = 0, n, dc = 0, rcn = 0;
    int          kohm [4] = '{30, 50, 200, 800};
    logic [7:0]  img [12];
    logic [23:0] sd [3];
    logic [24:0] note_q [$];
    logic [24:0] nt;

    always #5 clk_i = ~clk_i;

    dcb_top #(.MS_CYCLES(10)) i_dcb_top (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .eep_rd_o, .eep_addr_o, .eep_valid_i, .eep_data_i,
        .tick_4mhz_i, .osc_10k_i, .disp_cycle_i, .meas_active_i, .loading_i, .mp3_gpio_i,
        .diag_i, .irq_i, .aux_pin_i, .aux_pin_o, .aux_pin_oe_o, .aux_pull_up_o,
        .aux_pull_down_o, .seg_position_o, .seg_data_o, .charge_res_kohm_o, .comp_on_o,
        .fast_discharge_o, .ext_display_o, .ext_sck_o, .seg_spi_out_o,
        .first_common_pin_spi_o, .direct_drive_o, .recharge_o, .pump_tick_o, .display_on_o,
        .third_multipurpose_pin_o, .key_sync_speed_o, .nonlinearity_multiplier_o,
        .config_loaded_o
    );

    task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task summarize;
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task wait_cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask : wait_cyc

    // Cycles between two rising edges of a watched output
    task automatic rise_gap(input int w, output int k);
        int   e;
        logic s, p;
        e = 0;
        k = 0;
        p = 1'b1;
        for (int c = 0; c < 20000 && e < 2; c++) begin
            @(posedge clk_i);
            s = (w == 0) ? pump_tick_o : (w == 1) ? ext_sck_o : display_on_o;
            if (s === 1'b1 && p === 1'b0)
                e++;
            if (e == 1)
                k++;
            p = s;
        end
    endtask : rise_gap

    // Classic cycle; note queued first so the monitor can pair it with the ack
    task wb(input logic w, input logic [6:0] idx, input logic [23:0] d, input logic [23:0] e);
        note_q.push_back({~w, e});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= 4'hf;
        wb_dat_i <= {8'h00, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    // Image responder answers one cycle after each request; free-running sources
    always @(posedge clk_i) begin
        if (rc_on) begin
            dc += int'(disp_cycle_i);
            rcn += int'(recharge_o);
        end
        tick_4mhz_i <= ~tick_4mhz_i;
        {disp_cycle_i, meas_active_i, loading_i, mp3_gpio_i} <= 4'($urandom);
        diag_i <= 11'($urandom);
        if ($urandom_range(0, 49) == 0)
            osc_10k_i <= ~osc_10k_i;
        if (eep_rd_o === 1'b1) begin
            chk("eep_addr", 64'(eep_addr_o), 64'(36 + ld_n));
            eep_data_i  <= img[ld_n % 12];
            eep_valid_i <= 1'b1;
            ld_n++;
        end else begin
            eep_valid_i <= 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1) begin
            if (note_q.size() == 0)
                chk("ack_unasked", 64'h1, 64'h0);
            else begin
                nt = note_q.pop_front();
                if (nt[24])
                    chk("rdata", 64'(wb_dat_o), 64'(nt[23:0]));
            end
        end
    end

    initial begin
        repeat (50000) @(posedge clk_i);
        err_total++;
        summarize();
    end

    initial begin
        n = $urandom(98);
        foreach (img[i]) img[i] = 8'($urandom);
        img[8] = img[8] & 8'hc3;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("res_reset", 64'(charge_res_kohm_o), 64'd30);
        n = 0;
        while (config_loaded_o !== 1'b1 && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        chk("bytes_loaded", 64'(ld_n), 64'd12);
        chk("loaded", 64'(config_loaded_o), 64'h1);
        chk("nlk_out", 64'(nonlinearity_multiplier_o), 64'({img[9], img[10], img[11]}));
        wb(1'b0, 7'h3c, 24'h0, {img[0], img[1], img[2]});
        wb(1'b0, 7'h40, 24'h0, {img[3], img[4], img[5]});
        wb(1'b0, 7'h41, 24'h0, {img[6], img[7], img[8]});
        wb(1'b0, 7'h42, 24'h0, {img[9], img[10], img[11]});
        for (int i = 0; i < 3; i++)
            wb(1'b0, 7'h3d + 7'(i), 24'h0, 24'h0);
        // Unmapped place: write ignored, read gives zero
        wb(1'b1, 7'h10, 24'habcdef, 24'h0);
        wb(1'b0, 7'h10, 24'h0, 24'h0);
        wb(1'b1, 7'h3c, 24'h5a3c96, 24'h0);
        chk("seg_pos", 64'(seg_position_o), 64'h5a3c96);
        for (int i = 0; i < 3; i++) begin
            sd[i] = 24'($urandom);
            wb(1'b1, 7'h3d + 7'(i), sd[i], 24'h0);
        end
        wait_cyc(2);
        chk("seg_data", 64'(seg_data_o), 64'({sd[2][7:0], sd[1], sd[0]}));
        wb(1'b0, 7'h3f, 24'h0, {16'h0, sd[2][7:0]});
        wb(1'b1, 7'h40, 24'h4a000c, 24'h0);
        wait_cyc(2);
        chk("ctl_bits", 64'({ext_display_o, direct_drive_o, fast_discharge_o}), 64'h7);
        irq_i <= 1'b1;
        wait_cyc(3);
        chk("pin3_irq", 64'(third_multipurpose_pin_o), 64'h1);
        irq_i <= 1'b0;
        wait_cyc(3);
        chk("pin3_irq", 64'(third_multipurpose_pin_o), 64'h0);
        // Pin four output high; every direction code tried on pin five
        pw = {8'h00, 3'h3, 4'h1, 6'h05, 3'h5, 2'h3, 2'h0, 2'h0, 2'h1};
        for (int d = 0; d < 4; d++) begin
            pw[5:4] = 2'(d);
            wb(1'b1, 7'h41, pw[23:0], 24'h0);
            aux_pin_i <= {1'(d), 1'b0};
            wait_cyc(4);
            chk("aux_pins", 64'({aux_pin_oe_o, aux_pull_up_o, aux_pull_down_o, aux_pin_o[0]}),
                64'({d == 0, 1'b1, d == 1, 1'b0, d == 2, 1'b0, 1'b1}));
            wb(1'b0, 7'h41, 24'h0, {pw[23:8], d != 2, 1'b1, pw[5:0]});
        end
        chk("port_out", 64'({key_sync_speed_o, seg_spi_out_o, first_common_pin_spi_o}),
            64'h1b);
        rise_gap(1, n);
        chk("sck_period", 64'(n), 64'd200);
        // Pulse gap in clocks: one tick every two cycles, divider 480 + 5
        rise_gap(0, n);
        chk("pump_gap", 64'(n), 64'd970);
        // Recharge field 3: one recharge per four display cycles
        wb(1'b1, 7'h40, 24'h7a000c, 24'h0);
        rc_on <= 1'b1;
        wait_cyc(400);
        rc_on <= 1'b0;
        wait_cyc(1);
        chk("recharge", 64'(rcn * 4 <= dc + 5 && dc <= rcn * 4 + 5), 64'h1);
        // Blink 300 ms, on-time 100 ms, ten cycles per ms here
        rise_gap(2, n);
        chk("blink_period", 64'(n), 64'd3000);
        wait_cyc(999);
        chk("on_time", 64'(display_on_o), 64'h1);
        wait_cyc(1);
        chk("on_time", 64'(display_on_o), 64'h0);
        for (int r = 0; r < 4; r++) begin
            wb(1'b1, 7'h43, {20'h0, 2'h3, 2'(r)}, 24'h0);
            wait_cyc(2);
            chk("res_kohm", 64'(charge_res_kohm_o), 64'(kohm[r]));
            chk("comp_on", 64'(comp_on_o), 64'h1);
        end
        // Modes 1 and 2 follow random activity; the design's assertions judge them
        wb(1'b1, 7'h43, 24'h4, 24'h0);
        wait_cyc(20);
        wb(1'b1, 7'h43, 24'h8, 24'h0);
        wait_cyc(20);
        wb(1'b1, 7'h43, 24'h0, 24'h0);
        wait_cyc(2);
        chk("comp_off", 64'(comp_on_o), 64'h0);
        wait_cyc(2);
        summarize();
    end
endmodule : dcb_top_tb
`default_nettype wire
